// ===== hdl/edge_sync.sv
// Two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module edge_sync (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_ff, sync_ff, prev_ff; // Stages; sync_ff and prev_ff are looked at
    logic [2:0] nxt_stages;
    // Next values of the chain
    always_comb begin
        nxt_stages = {async_in, meta_ff, sync_ff};
    end
    // Register the chain
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            {meta_ff, sync_ff, prev_ff} <= 3'h0;
        end else begin
            {meta_ff, sync_ff, prev_ff} <= nxt_stages;
        end
    end
    assign level = sync_ff;
    assign rise = sync_ff & ~prev_ff;
    assign fall = ~sync_ff & prev_ff;
endmodule : edge_sync

// ===== hdl/prescaler.sv
// Power-of-two prescaler producing a count enable pulse
`timescale 1ns/1ps
module prescaler (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic tick_in,
    input wire logic [2:0] shift,
    output logic tick_out
);
    logic [6:0] div_ff; // Divider count
    logic [6:0] nxt_div;
    logic [6:0] limit;
    // Next divider value; wraps at 2^shift-1
    always_comb begin
        limit = 7'((8'h01 << shift) - 8'h01);
        nxt_div = div_ff;
        if (tick_in) begin
            nxt_div = (div_ff >= limit) ? 7'h00 : 7'(div_ff + 7'h01);
        end
    end
    // Register the divider
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            div_ff <= 7'h00;
        end else begin
            div_ff <= nxt_div;
        end
    end
    assign tick_out = tick_in && (div_ff >= limit);
endmodule : prescaler

// ===== hdl/timer_channel_pin_control.sv
// Timer/PWM unit: clock select, counter, channel pin ownership and drive
`timescale 1ns/1ps
`include "timer_pin_consts.svh"
module timer_channel_pin_control import timer_pin_pkg::*; #(
    parameter int N_CH = 2,
    parameter int EXT_CH = 0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic fixed_tick,
    input wire logic external_count_clock_input,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rdata,
    input wire logic [N_CH-1:0] channel_pin_in,
    output logic [N_CH-1:0] channel_pin_out,
    output logic [N_CH-1:0] channel_pin_oe_n,
    output logic [N_CH-1:0] channel_pin_owned,
    output logic irq
);
    // Elaboration check: the 4-bit register map holds channel pairs only up to 0xf,
    // so more than four channels would alias onto the control registers
    if (N_CH < 1 || N_CH > 4 || EXT_CH < 0 || EXT_CH >= N_CH) begin : g_bad_params
        $error("timer_channel_pin_control: bad channel parameters");
    end

    // Control register fields
    logic [7:0] ctrl_ff; // [7:6] spare, [5] center align, [4:3] clock, [2:0] prescale
    logic [15:0] mod_ff; // Counter modulo
    logic [15:0] cnt_ff; // Counter
    logic down_ff; // Center-aligned direction
    logic [N_CH:0] status_ff; // Channel flags, top bit overflow
    logic [N_CH:0] mask_ff; // Interrupt enables
    logic [3:0] ch_ctrl_ff [N_CH]; // [3:2] mode, [1:0] edge/level
    logic [15:0] ch_val_ff [N_CH]; // Channel value
    logic [N_CH-1:0] pin_ff, oe_n_ff, owned_ff;
    logic [15:0] rdata_ff;
    logic irq_ff;

    logic [7:0] nxt_ctrl;
    logic [15:0] nxt_mod, nxt_cnt, nxt_rdata;
    logic nxt_down, nxt_irq;
    logic [N_CH:0] nxt_status, nxt_mask;
    logic [3:0] nxt_ch_ctrl [N_CH];
    logic [15:0] nxt_ch_val [N_CH];
    logic [N_CH-1:0] nxt_pin, nxt_oe_n, nxt_owned;

    logic center, clk_tick, cnt_tick, ext_rise;
    logic [1:0] clk_sel;
    logic [N_CH-1:0] cap_level, cap_rise, cap_fall;
    logic overflow;

    assign center = ctrl_ff[5];
    assign clk_sel = ctrl_ff[4:3];

    // Function a channel performs given its controls
    function automatic ch_func_t ch_func(input logic [3:0] cc, input logic cen,
                                         input logic [1:0] cs);
        if (cc[1:0] == `ELS_OFF || cs == `CLK_NONE) begin
            return CH_RELEASED; // [RULE_05]
        end else if (cen) begin
            return CH_CENTER_PWM; // [RULE_06]
        end else if (cc[3]) begin
            return CH_EDGE_PWM; // [RULE_07]
        end else if (cc[3:2] == `MODE_CAPTURE) begin
            return CH_CAPTURE; // [RULE_07]
        end else begin
            return CH_COMPARE; // [RULE_07]
        end
    endfunction : ch_func

    // Channel pin synchronisers; capture edges are only seen after two stages
    for (genvar i = 0; i < N_CH; i++) begin : g_sync
        edge_sync u_sync (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .async_in(channel_pin_in[i]),
            .level(cap_level[i]),
            .rise(cap_rise[i]),
            .fall(cap_fall[i])
        ); // [RULE_09]
    end

    // External clock shares the channel pin; its rising edge is one count
    assign ext_rise = cap_rise[EXT_CH]; // [RULE_02]

    // Source selection ahead of the prescaler
    always_comb begin
        unique case (clk_sel) // [RULE_17]
            `CLK_NONE: clk_tick = 1'b0; // [RULE_01]
            `CLK_BUS: clk_tick = 1'b1;
            `CLK_FIXED: clk_tick = fixed_tick;
            `CLK_EXT: clk_tick = ext_rise;
        endcase
    end

    prescaler u_presc (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tick_in(clk_tick),
        .shift(ctrl_ff[2:0]),
        .tick_out(cnt_tick)
    );

    // Counter: up to modulo then wrap, or up/down in center mode
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_down = down_ff;
        overflow = 1'b0;
        if (cnt_tick) begin
            if (center) begin
                if (!down_ff) begin
                    if (cnt_ff >= mod_ff) begin
                        nxt_down = 1'b1; // [RULE_18]
                        nxt_cnt = 16'(cnt_ff - 16'h0001);
                    end else begin
                        nxt_cnt = 16'(cnt_ff + 16'h0001);
                    end
                end else if (cnt_ff <= 16'h0001) begin
                    nxt_cnt = 16'h0000; // [RULE_18]
                    nxt_down = (cnt_ff == 16'h0000) ? 1'b0 : 1'b1;
                    overflow = (cnt_ff == 16'h0001);
                    if (cnt_ff == 16'h0000) begin
                        nxt_down = 1'b0;
                        nxt_cnt = 16'h0001;
                    end
                end else begin
                    nxt_cnt = 16'(cnt_ff - 16'h0001);
                end
            end else begin
                nxt_down = 1'b0;
                if (mod_ff != 16'h0000 && cnt_ff >= mod_ff) begin
                    nxt_cnt = 16'h0000;
                    overflow = 1'b1;
                end else begin
                    nxt_cnt = 16'(cnt_ff + 16'h0001);
                    overflow = (cnt_ff == 16'hffff);
                end
            end
        end
        if (wr_en && addr == `ADDR_CNT) begin
            nxt_cnt = 16'h0000;
            nxt_down = 1'b0;
        end
    end

    // Channel pin logic, flags and registers
    always_comb begin
        ch_func_t f;
        logic match;
        logic [1:0] els;
        f = CH_RELEASED;
        match = 1'b0;
        els = 2'h0;
        nxt_ctrl = ctrl_ff;
        nxt_mod = mod_ff;
        nxt_mask = mask_ff;
        nxt_status = status_ff;
        nxt_pin = pin_ff;
        nxt_oe_n = oe_n_ff;
        nxt_owned = owned_ff;
        for (int i = 0; i < N_CH; i++) begin
            nxt_ch_ctrl[i] = ch_ctrl_ff[i];
            nxt_ch_val[i] = ch_val_ff[i];
        end
        // Software writes; write-one clears status
        if (wr_en) begin
            if (addr == `ADDR_CTRL) nxt_ctrl = wdata[7:0];
            if (addr == `ADDR_MOD) nxt_mod = wdata;
            if (addr == `ADDR_MASK) nxt_mask = wdata[N_CH:0];
            if (addr == `ADDR_STATUS) nxt_status = status_ff & ~wdata[N_CH:0];
            for (int i = 0; i < N_CH; i++) begin
                if (addr == 4'(`ADDR_CH_BASE + 2 * i)) nxt_ch_ctrl[i] = wdata[3:0];
                if (addr == 4'(`ADDR_CH_BASE + 2 * i + 1)) nxt_ch_val[i] = wdata;
            end
        end
        // Hardware events win over a clear in the same cycle
        if (overflow) nxt_status[N_CH] = 1'b1;
        for (int i = 0; i < N_CH; i++) begin
            f = ch_func(ch_ctrl_ff[i], center, clk_sel);
            els = ch_ctrl_ff[i][1:0];
            match = cnt_tick && (cnt_ff == ch_val_ff[i]);
            nxt_owned[i] = (f != CH_RELEASED); // [RULE_05]
            nxt_oe_n[i] = !(f != CH_RELEASED && f != CH_CAPTURE); // [RULE_10]
            unique case (f)
                CH_RELEASED: begin
                    // Software timer: flag on match in compare mode with center align off, pin untouched [RULE_04]
                    if (match && ch_ctrl_ff[i][3:2] == `MODE_COMPARE && !center) begin
                        nxt_status[i] = 1'b1;
                    end
                end
                CH_CAPTURE: begin
                    // Edge input, data direction overridden [RULE_08]
                    nxt_pin[i] = cap_level[i];
                    if ((els[0] && cap_rise[i]) || (els[1] && cap_fall[i])) begin
                        nxt_ch_val[i] = cnt_ff; // [RULE_08]
                        nxt_status[i] = 1'b1;
                    end
                end
                CH_COMPARE: begin
                    // Toggle starts from the level already on the pin [RULE_11]
                    if (match) begin
                        nxt_status[i] = 1'b1;
                        unique case (els) // [RULE_16]
                            `ELS_TOGGLE: nxt_pin[i] = ~pin_ff[i]; // [RULE_10]
                            `ELS_CLEAR: nxt_pin[i] = 1'b0;
                            `ELS_SET: nxt_pin[i] = 1'b1;
                            default: nxt_pin[i] = pin_ff[i];
                        endcase
                    end
                end
                CH_EDGE_PWM: begin
                    if (cnt_tick && cnt_ff == 16'h0000) begin
                        nxt_pin[i] = ~els[0]; // [RULE_12] [RULE_13]
                    end
                    if (match) begin
                        nxt_pin[i] = els[0]; // [RULE_12] [RULE_13]
                        nxt_status[i] = 1'b1;
                    end
                end
                CH_CENTER_PWM: begin
                    if (match) begin
                        nxt_status[i] = 1'b1;
                        // Up: inactive level, down: active level [RULE_14] [RULE_15]
                        nxt_pin[i] = down_ff ? ~els[0] : els[0];
                    end
                end
                default: nxt_pin[i] = pin_ff[i];
            endcase
        end
        nxt_irq = |(nxt_status & nxt_mask);
        // Read data, valid the cycle after the strobe
        nxt_rdata = 16'h0000;
        if (rd_en) begin
            unique case (addr)
                `ADDR_CTRL: nxt_rdata = {8'h00, ctrl_ff};
                `ADDR_MOD: nxt_rdata = mod_ff;
                `ADDR_CNT: nxt_rdata = cnt_ff;
                `ADDR_STATUS: nxt_rdata = 16'(status_ff);
                `ADDR_MASK: nxt_rdata = 16'(mask_ff);
                default: begin
                    for (int i = 0; i < N_CH; i++) begin
                        if (addr == 4'(`ADDR_CH_BASE + 2 * i)) begin
                            nxt_rdata = {12'h000, ch_ctrl_ff[i]};
                        end
                        if (addr == 4'(`ADDR_CH_BASE + 2 * i + 1)) begin
                            nxt_rdata = ch_val_ff[i];
                        end
                    end
                end
            endcase
        end
    end

    // Register all state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_ff <= `CTRL_RESET;
            mod_ff <= 16'h0000;
            cnt_ff <= 16'h0000;
            down_ff <= 1'b0;
            status_ff <= '0;
            mask_ff <= '0;
            pin_ff <= '0;
            oe_n_ff <= '1;
            owned_ff <= '0;
            rdata_ff <= 16'h0000;
            irq_ff <= 1'b0;
            for (int i = 0; i < N_CH; i++) begin
                ch_ctrl_ff[i] <= 4'h0;
                ch_val_ff[i] <= 16'h0000;
            end
        end else begin
            ctrl_ff <= nxt_ctrl;
            mod_ff <= nxt_mod;
            cnt_ff <= nxt_cnt;
            down_ff <= nxt_down;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            pin_ff <= nxt_pin;
            oe_n_ff <= nxt_oe_n;
            owned_ff <= nxt_owned;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            for (int i = 0; i < N_CH; i++) begin
                ch_ctrl_ff[i] <= nxt_ch_ctrl[i];
                ch_val_ff[i] <= nxt_ch_val[i];
            end
        end
    end

    assign rdata = rdata_ff;
    assign channel_pin_out = pin_ff;
    assign channel_pin_oe_n = oe_n_ff;
    assign channel_pin_owned = owned_ff;
    assign irq = irq_ff;
endmodule : timer_channel_pin_control

// ===== include/timer_pin_consts.svh
// Constants of the timer channel pin controller
//
// Function
// [RULE_01] Clock select: none, bus, fixed, external
// [RULE_02] External clock synchronised, at most bus/4
// [RULE_03] Software avoids sharing clock pin with channel
// [RULE_04] External clock keeps software compare timing
// [RULE_05] Pin released when edge/level or clock zero
// [RULE_06] Center-align puts all channels in PWM
// [RULE_07] Mode field picks capture, compare, edge PWM
// [RULE_08] Capture pin is edge input, chosen polarity
// [RULE_09] Capture edges synchronised; four-cycle pulses
// [RULE_10] Compare drives pin on channel value match
// [RULE_11] Toggle keeps previous level until match
// [RULE_12] Edge PWM 1:0 high at zero, low match
// [RULE_13] Edge PWM low bit set inverts polarity
// [RULE_14] Center PWM 1:0 clear up, set down
// [RULE_15] Center PWM low bit set: set up, clear down
// [RULE_16] Compare 01 toggle, 10 clear, 11 set
// [RULE_17] Clock select codes 00,01,10,11
// [RULE_18] Center count up to modulo, down to zero
`ifndef TIMER_PIN_CONSTS_SVH
`define TIMER_PIN_CONSTS_SVH
`define CLK_NONE 2'h0
`define CLK_BUS 2'h1
`define CLK_FIXED 2'h2
`define CLK_EXT 2'h3
`define ELS_OFF 2'h0
`define ELS_TOGGLE 2'h1
`define ELS_CLEAR 2'h2
`define ELS_SET 2'h3
`define MODE_CAPTURE 2'h0
`define MODE_COMPARE 2'h1
`define ADDR_CTRL 4'h0
`define ADDR_MOD 4'h1
`define ADDR_CNT 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_MASK 4'h4
`define ADDR_CH_BASE 4'h8
`define CTRL_RESET 8'h00
`define EXT_MAX_RATIO 4
`endif

// ===== include/timer_pin_pkg.sv
// Types of the timer channel pin controller
package timer_pin_pkg;
    // Function a channel performs
    typedef enum logic [2:0] {
        CH_RELEASED = 3'b000,
        CH_CAPTURE = 3'b001,
        CH_COMPARE = 3'b010,
        CH_EDGE_PWM = 3'b011,
        CH_CENTER_PWM = 3'b100
    } ch_func_t;
endpackage : timer_pin_pkg

// ===== verification/pin_world_model.sv
// Model of the outside world seen at the timer channel pins
`timescale 1ns/1ps
module pin_world_model #(
    parameter int N_CH = 2
) (
    input wire logic [N_CH-1:0] pin_out,
    input wire logic [N_CH-1:0] pin_oe_n,
    input wire logic [N_CH-1:0] ext_level,
    output logic [N_CH-1:0] pin_in
);
    // Driven pins read back their own level; released pins carry the outside
    // level, whose pulses the bench keeps at four bus cycles or more
    always_comb begin
        for (int i = 0; i < N_CH; i++) begin
            pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
        end
    end
endmodule : pin_world_model

// ===== verification/timer_channel_pin_control_test.sv
// Self-checking bench for the timer channel pin controller
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin mismatches++; \
    $display("MISMATCH %s expected %0h seen %0h", n, e, s); end end
module timer_channel_pin_control_test;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic fixed_tick = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [1:0] ext = 2'h0; // Outside level on released pins
    logic [15:0] rdata;
    logic [1:0] pin_in;
    logic [1:0] pin_out;
    logic [1:0] oe_n;
    logic [1:0] owned;
    logic irq;
    logic [15:0] cv [4] = '{16'h0000, 16'h0001, 16'h0005, 16'h0009};
    int mismatches = 0;
    int comparisons = 0;
    int hi;
    always #5 ref_clk = ~ref_clk;
    timer_channel_pin_control u_timer_channel_pin_control (
        .ref_clk(ref_clk), .rst_n(rst_n), .fixed_tick(fixed_tick),
        .external_count_clock_input(1'b0), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .channel_pin_in(pin_in),
        .channel_pin_out(pin_out), .channel_pin_oe_n(oe_n),
        .channel_pin_owned(owned), .irq(irq));
    pin_world_model u_pin_world_model (.pin_out(pin_out), .pin_oe_n(oe_n),
        .ext_level(ext), .pin_in(pin_in));
    // One register write and an idle cycle
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    // One register read, data checked in the following cycle
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        `CHK("rdata", e, rdata)
        @(posedge ref_clk);
    endtask : rd
    // Count cycles with channel 0 high
    task automatic duty(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            hi += int'(pin_out[0] === 1'b1);
        end
    endtask : duty
    // Outside pulse on pin 0, four cycles high and four low
    task automatic pulse();
        ext[0] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ext[0] <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : pulse
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        #20000;
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        `CHK("owned", 2'b00, owned)
        `CHK("oe_n", 2'b11, oe_n)
        rd(4'h7, 16'h0000);
        wr(4'h2, 16'h0000);
        repeat (20) @(posedge ref_clk);
        rd(4'h2, 16'h0000);
        wr(4'h0, 16'h0010);
        wr(4'h2, 16'h0000);
        repeat (5) begin
            fixed_tick <= 1'b1;
            @(posedge ref_clk);
            fixed_tick <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
        rd(4'h2, 16'h0005);
        wr(4'h0, 16'h0018);
        wr(4'h2, 16'h0000);
        repeat (3) pulse();
        rd(4'h2, 16'h0003);
        `CHK("owned", 2'b00, owned)
        $display("clock select test done");
        wr(4'h0, 16'h0008);
        foreach (cv[i]) begin
            wr(4'h8, cv[i]);
            #1;
            `CHK("owned", i != 0, owned[0])
            `CHK("oe_n", i < 2, oe_n[0])
        end
        wr(4'h0, 16'h0028);
        #1;
        `CHK("oe_n", 2'b10, oe_n)
        wr(4'h0, 16'h0020);
        #1;
        `CHK("owned", 2'b00, owned)
        $display("ownership test done");
        wr(4'h0, 16'h0008);
        wr(4'h1, 16'h0010);
        wr(4'h9, 16'h000a);
        wr(4'h8, 16'h0007);
        repeat (20) @(posedge ref_clk);
        #1;
        `CHK("set", 1'b1, pin_out[0])
        wr(4'h8, 16'h0006);
        repeat (20) @(posedge ref_clk);
        #1;
        `CHK("clear", 1'b0, pin_out[0])
        wr(4'h2, 16'h0000);
        wr(4'h8, 16'h0005);
        #1;
        `CHK("hold", 1'b0, pin_out[0])
        repeat (12) @(posedge ref_clk);
        #1;
        `CHK("toggle", 1'b1, pin_out[0])
        $display("compare test done");
        wr(4'h1, 16'h0008);
        wr(4'h9, 16'h0005);
        wr(4'h2, 16'h0000);
        wr(4'h8, 16'h000a);
        duty(12);
        duty(36);
        `CHK("edge_hi", 20, hi)
        wr(4'h8, 16'h0009);
        duty(12);
        duty(36);
        `CHK("edge_lo", 16, hi)
        wr(4'h0, 16'h0028);
        wr(4'h2, 16'h0000);
        wr(4'ha, 16'h0002);
        #1;
        `CHK("oe_n", 2'b00, oe_n)
        wr(4'h8, 16'h0002);
        duty(16);
        duty(32);
        `CHK("center_hi", 20, hi)
        wr(4'h8, 16'h0001);
        duty(16);
        duty(32);
        `CHK("center_lo", 12, hi)
        $display("pwm test done");
        wr(4'h0, 16'h0008);
        wr(4'h8, 16'h0003);
        wr(4'ha, 16'h0004);
        wr(4'hb, 16'h0003);
        wr(4'h4, 16'h0000);
        wr(4'h3, 16'h0007);
        pulse();
        rd(4'h3, 16'h0007);
        #1;
        `CHK("irq", 1'b0, irq)
        `CHK("owned", 2'b01, owned)
        wr(4'h4, 16'h0001);
        #1;
        `CHK("irq", 1'b1, irq)
        wr(4'h3, 16'h0001);
        #1;
        `CHK("irq", 1'b0, irq)
        // Pin 0 as external clock, channel 0 kept as a software timer
        wr(4'h0, 16'h0018);
        wr(4'h8, 16'h0004);
        wr(4'h9, 16'h0002);
        wr(4'h2, 16'h0000);
        wr(4'h3, 16'h0007);
        repeat (3) pulse();
        rd(4'h3, 16'h0001);
        #1;
        `CHK("owned", 2'b00, owned)
        `CHK("irq", 1'b1, irq)
        $display("capture test done");
        end_sim();
    end
endmodule : timer_channel_pin_control_test

// ===== verification/timer_pin_checker.sv
// Checker of channel pin ownership and compare drive
`timescale 1ns/1ps
module timer_pin_checker #(
    parameter int N_CH = 2
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic [N_CH-1:0] channel_pin_out,
    input wire logic [N_CH-1:0] channel_pin_oe_n,
    input wire logic [N_CH-1:0] channel_pin_owned
);
    logic [5:0] ctl_ff; // Shadow of center and clock select
    logic [3:0] ch0_ff; // Shadow of channel 0 control
    logic [3:0] ch1_ff; // Shadow of channel 1 control
    logic run;
    logic cpwm;
    logic [1:0] els;
    logic [1:0] md;
    assign run = ctl_ff[4:3] != 2'h0;
    assign cpwm = ctl_ff[5];
    assign els = ch0_ff[1:0];
    assign md = ch0_ff[3:2];
    // Follow writes the way the register file takes them
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl_ff <= 6'h00;
            ch0_ff <= 4'h0;
            ch1_ff <= 4'h0;
        end else if (wr_en) begin
            if (addr == 4'h0) ctl_ff <= wdata[5:0];
            if (addr == 4'h8) ch0_ff <= wdata[3:0];
            if (addr == 4'ha) ch1_ff <= wdata[3:0];
        end
    end
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    pin_release_a: assert property (
        (els == 2'h0 || !run) |=> !channel_pin_owned[0] && channel_pin_oe_n[0])
        else $error("channel 0 pin not released");
    no_clock_a: assert property (!run |=> channel_pin_owned == '0)
        else $error("pins owned without clock");
    capture_input_a: assert property (
        (run && !cpwm && md == 2'h0 && els != 2'h0)
        |=> channel_pin_owned[0] && channel_pin_oe_n[0])
        else $error("capture pin not an owned input");
    compare_drive_a: assert property (
        (run && !cpwm && md == 2'h1 && els != 2'h0)
        |=> channel_pin_owned[0] && !channel_pin_oe_n[0])
        else $error("compare pin not driven");
    edge_pwm_a: assert property (
        (run && !cpwm && md[1] && els != 2'h0) |=> !channel_pin_oe_n[0])
        else $error("edge pwm pin not driven");
    center_all_a: assert property (
        (run && cpwm && ch1_ff[1:0] != 2'h0) |=> !channel_pin_oe_n[1])
        else $error("center pwm pin not driven");
    set_only_a: assert property (
        (run && !cpwm && ch0_ff == 4'h7) [*2] |=> !$fell(channel_pin_out[0]))
        else $error("set action lowered pin");
    clear_only_a: assert property (
        (run && !cpwm && ch0_ff == 4'h6) [*2] |=> !$rose(channel_pin_out[0]))
        else $error("clear action raised pin");
endmodule : timer_pin_checker
bind timer_channel_pin_control timer_pin_checker #(.N_CH(N_CH)) u_timer_pin_checker (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .channel_pin_out(channel_pin_out), .channel_pin_oe_n(channel_pin_oe_n),
    .channel_pin_owned(channel_pin_owned));
